// file: rtl/mdu_top.sv
// memory-mapped multiplier/divider with apb slave and interrupt
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
// What this block does
// - multiply mode: unsigned 16x16 into full 32-bit product
// - divide mode: 32/32 giving 32-bit quotient and remainder
// - multiply: operand A high is multiplier, A low multiplicand
// - divide: operand A pair is dividend, overwritten by quotient
// - reset clears all four operand registers to zero
// - operand registers are written as whole 16-bit words
// - operand A reads during a division are not guaranteed
// - multiply: product goes to operand B pair, high and low
// - divide: operand B pair supplies the 32-bit divisor
// - control bit 7 selects multiply (0) or divide (1)
// - divide starts on go bit, self-clears at end, raises interrupt
// - multiply starts after both A halves written, ready next clock
// - division finishes within sixteen clocks of its start
// - divide remainder goes to read-only remainder pair
module mdu_top (
  input  wire logic        clock,    // 100 mhz system clock
  input  wire logic        nrst,     // synchronous reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb write
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  input  wire logic [3:0]  pstrb,    // apb byte strobes
  output logic      [31:0] prdata,   // apb read data, registered
  output logic             pready,   // apb ready, registered
  output logic             pslverr,  // apb error, registered
  output logic             irq       // level interrupt, registered
);
  mdu_pkg::mdu_apb_req_t req;

  logic [15:0] aLow_r;
  logic [15:0] aHigh_r;
  logic [15:0] bLow_r;
  logic [15:0] bHigh_r;
  logic [15:0] remLow_r;
  logic [15:0] remHigh_r;
  logic        opSelect_r;
  logic        divideGo_r;
  logic        aLowSeen_r;
  logic        aHighSeen_r;
  logic        mulPending_r;
  logic [1:0]  status_r;
  logic [1:0]  mask_r;
  logic [1:0]  status_nxt;

  logic        setupPhase;
  logic        wrAccess;
  logic        rdAccess;
  logic        hitALow;
  logic        hitAHigh;
  logic        hitBLow;
  logic        hitBHigh;
  logic        hitRemLow;
  logic        hitRemHigh;
  logic        hitControl;
  logic        hitStatus;
  logic        hitMask;
  logic        hitAny;
  logic        wordWrite;
  logic        divStart;
  logic        divBusy;
  logic        divDone;
  logic [31:0] quotient;
  logic [31:0] remainder;
  logic [31:0] product;
  logic [31:0] readMux;
  logic [7:0]  controlView;
  logic [1:0]  events;
  logic        aLowNow;
  logic        aHighNow;
  logic        mulArm;

  // bundle the bus request
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  // address decode; ready is given one cycle after setup
  assign setupPhase = req.sel && !req.enable;
  assign wrAccess   = req.sel && req.enable && pready && req.write;
  assign rdAccess   = req.sel && req.enable && pready && !req.write;
  assign hitALow    = req.addr == mdu_pkg::OFS_A_LOW;
  assign hitAHigh   = req.addr == mdu_pkg::OFS_A_HIGH;
  assign hitBLow    = req.addr == mdu_pkg::OFS_B_LOW;
  assign hitBHigh   = req.addr == mdu_pkg::OFS_B_HIGH;
  assign hitRemLow  = req.addr == mdu_pkg::OFS_REM_LOW;
  assign hitRemHigh = req.addr == mdu_pkg::OFS_REM_HIGH;
  assign hitControl = req.addr == mdu_pkg::OFS_CONTROL;
  assign hitStatus  = req.addr == mdu_pkg::OFS_STATUS;
  assign hitMask    = req.addr == mdu_pkg::OFS_MASK;
  assign hitAny     = hitALow | hitAHigh | hitBLow | hitBHigh | hitRemLow
                    | hitRemHigh | hitControl | hitStatus | hitMask;
  // operands take whole 16-bit words only: both low strobes needed
  assign wordWrite  = wrAccess && (pstrb[1:0] == 2'b11);

  // go bit is honoured only in divide mode and only when idle
  assign divStart = wrAccess && hitControl && pstrb[0] && !divBusy
                  && pwdata[mdu_pkg::CTL_OP_SELECT_BIT]
                  && pwdata[mdu_pkg::CTL_DIVIDE_GO_BIT];

  // multiply arms on the edge that commits the second A half
  assign aLowNow  = aLowSeen_r | (wordWrite && hitALow);
  assign aHighNow = aHighSeen_r | (wordWrite && hitAHigh);
  assign mulArm   = !opSelect_r && aLowNow && aHighNow;

  // single-cycle unsigned multiply, full width kept
  assign product = {16'h0000, aHigh_r} * {16'h0000, aLow_r};

  // control view: mode bit 7, go bit 0, others zero
  assign controlView = {opSelect_r, 6'h00, divideGo_r};

  // read multiplexer; unmapped addresses read zero
  assign readMux =
      hitALow    ? {16'h0000, aLow_r}    :
      hitAHigh   ? {16'h0000, aHigh_r}   :
      hitBLow    ? {16'h0000, bLow_r}    :
      hitBHigh   ? {16'h0000, bHigh_r}   :
      hitRemLow  ? {16'h0000, remLow_r}  :
      hitRemHigh ? {16'h0000, remHigh_r} :
      hitControl ? {24'h000000, controlView} :
      hitStatus  ? {30'h0, status_r}     :
      hitMask    ? {30'h0, mask_r}       : 32'h00000000;

  // event sources: divide done pulse, multiply result landing
  assign events = {mulPending_r, divDone};

  // sticky status: a new event wins over the read-clear
  assign status_nxt = ((rdAccess && hitStatus) ? 2'b00 : status_r) | events;

  mdu_div_core #(
    .WIDTH     (32)
  ) u_div (
    .clock     (clock),
    .nrst      (nrst),
    .start     (divStart),
    .dividend  ({aHigh_r, aLow_r}),
    .divisor   ({bHigh_r, bLow_r}),
    .busy      (divBusy),
    .done      (divDone),
    .quotient  (quotient),
    .remainder (remainder)
  );

  // apb handshake: no wait states, error on unmapped address
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !hitAny;
      prdata  <= (setupPhase && !req.write) ? readMux : 32'h00000000;
    end
  end

  // operand A: software writes, quotient overwrites at divide end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      aLow_r  <= mdu_pkg::RST_OPERAND;
      aHigh_r <= mdu_pkg::RST_OPERAND;
    end
    else if (divDone)
    begin
      aHigh_r <= quotient[31:16];
      aLow_r  <= quotient[15:0];
    end
    else
    begin
      // writes during a division are taken but then overwritten by the quotient at divide end
      if (wordWrite && hitALow)
        aLow_r <= pwdata[15:0];
      if (wordWrite && hitAHigh)
        aHigh_r <= pwdata[15:0];
    end
  end

  // operand B: divisor input, product destination
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      bLow_r  <= mdu_pkg::RST_OPERAND;
      bHigh_r <= mdu_pkg::RST_OPERAND;
    end
    else if (mulPending_r)
    begin
      bHigh_r <= product[31:16];
      bLow_r  <= product[15:0];
    end
    else
    begin
      if (wordWrite && hitBLow)
        bLow_r <= pwdata[15:0];
      if (wordWrite && hitBHigh)
        bHigh_r <= pwdata[15:0];
    end
  end

  // remainder pair: read-only, loaded only at divide end
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      remLow_r  <= mdu_pkg::RST_OPERAND;
      remHigh_r <= mdu_pkg::RST_OPERAND;
    end
    else if (divDone)
    begin
      remHigh_r <= remainder[31:16];
      remLow_r  <= remainder[15:0];
    end
  end

  // multiply trigger: arming on the second write itself keeps the
  // product only one clock behind it
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      aLowSeen_r   <= 1'b0;
      aHighSeen_r  <= 1'b0;
      mulPending_r <= 1'b0;
    end
    else
    begin
      mulPending_r <= mulArm;
      if (mulArm || opSelect_r)
      begin
        aLowSeen_r  <= 1'b0;
        aHighSeen_r <= 1'b0;
      end
      else
      begin
        aLowSeen_r  <= aLowNow;
        aHighSeen_r <= aHighNow;
      end
    end
  end

  // control: mode bit writable, go bit set only by a valid start
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      opSelect_r <= mdu_pkg::RST_CONTROL[mdu_pkg::CTL_OP_SELECT_BIT];
      divideGo_r <= mdu_pkg::RST_CONTROL[mdu_pkg::CTL_DIVIDE_GO_BIT];
    end
    else
    begin
      // mode held while busy so a running divide cannot be redirected
      if (wrAccess && hitControl && pstrb[0] && !divBusy)
        opSelect_r <= pwdata[mdu_pkg::CTL_OP_SELECT_BIT];
      if (divStart)
        divideGo_r <= 1'b1;
      else if (divDone)
        divideGo_r <= 1'b0;
    end
  end

  // interrupt status, mask and output level
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      status_r <= mdu_pkg::RST_IRQ;
      mask_r   <= mdu_pkg::RST_IRQ;
      irq      <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wrAccess && hitMask && pstrb[0])
        mask_r <= pwdata[1:0];
      irq <= |(status_nxt & mask_r);
    end
  end
endmodule

// file: common/mdu_pkg.sv
// package: register map, field layout and timing constants of the mul/div unit
package mdu_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_A_LOW   = 8'h00;
  localparam logic [7:0] OFS_A_HIGH  = 8'h04;
  localparam logic [7:0] OFS_B_LOW   = 8'h08;
  localparam logic [7:0] OFS_B_HIGH  = 8'h0c;
  localparam logic [7:0] OFS_REM_LOW = 8'h10;
  localparam logic [7:0] OFS_REM_HIGH= 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_MASK    = 8'h20;
  // control field positions
  localparam int CTL_OP_SELECT_BIT = 7;
  localparam int CTL_DIVIDE_GO_BIT = 0;
  // reset values
  localparam logic [15:0] RST_OPERAND = 16'h0000;
  localparam logic [7:0]  RST_CONTROL = 8'h00;
  localparam logic [1:0]  RST_IRQ     = 2'h0;
  // status bits: divide done, multiply done
  localparam int ST_DIV_DONE_BIT = 0;
  localparam int ST_MUL_DONE_BIT = 1;
  // timing: division lasts this many clocks
  localparam int DIV_CLOCKS = 16;
  localparam int DIV_BITS_PER_CLK = 2;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mdu_apb_req_t;
endpackage

// file: rtl/mdu_div_core.sv
// radix-4 restoring divider core, two quotient bits per clock
`timescale 1ns/10ps
module mdu_div_core #(
  parameter int WIDTH = 32                 // operand width
) (
  input  wire logic             clock,     // system clock
  input  wire logic             nrst,      // synchronous reset, active low
  input  wire logic             start,     // one-cycle start pulse
  input  wire logic [WIDTH-1:0] dividend,  // dividend, sampled on start
  input  wire logic [WIDTH-1:0] divisor,   // divisor, sampled on start
  output logic                  busy,      // high while dividing
  output logic                  done,      // high during the last step
  output logic [WIDTH-1:0]      quotient,  // final quotient while done
  output logic [WIDTH-1:0]      remainder  // final remainder while done
);
  localparam int STEPS = WIDTH / mdu_pkg::DIV_BITS_PER_CLK;

  logic [WIDTH-1:0] quo_r;
  logic [WIDTH-1:0] rem_r;
  logic [WIDTH-1:0] dvs_r;
  logic [5:0]       cnt_r;
  logic [WIDTH-1:0] quoStep;
  logic [WIDTH-1:0] remStep;

  // one restoring step: shift in a dividend bit, subtract when it fits
  function automatic logic [2*WIDTH-1:0] divStep(
    input logic [WIDTH-1:0] rem,
    input logic [WIDTH-1:0] quo,
    input logic [WIDTH-1:0] dvs
  );
    logic [WIDTH:0] trial;
    logic [WIDTH:0] diff;
    trial = {rem, quo[WIDTH-1]};
    diff  = trial - {1'b0, dvs};
    if (!diff[WIDTH])
      divStep = {diff[WIDTH-1:0], quo[WIDTH-2:0], 1'b1};
    else
      divStep = {trial[WIDTH-1:0], quo[WIDTH-2:0], 1'b0};
  endfunction

  // two steps chained so the whole divide takes 16 clocks
  always_comb
  begin
    logic [2*WIDTH-1:0] s1;
    logic [2*WIDTH-1:0] s2;
    s1 = divStep(rem_r, quo_r, dvs_r);
    s2 = divStep(s1[2*WIDTH-1:WIDTH], s1[WIDTH-1:0], dvs_r);
    remStep = s2[2*WIDTH-1:WIDTH];
    quoStep = s2[WIDTH-1:0];
  end

  // iteration registers; a zero divisor just yields all-ones quotient
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      quo_r <= '0;
      rem_r <= '0;
      dvs_r <= '0;
      cnt_r <= '0;
      busy  <= 1'b0;
    end
    else
    begin
      if (start && !busy)
      begin
        quo_r <= dividend;
        rem_r <= '0;
        dvs_r <= divisor;
        cnt_r <= 6'(STEPS);
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        quo_r <= quoStep;
        rem_r <= remStep;
        cnt_r <= cnt_r - 6'd1;
        if (cnt_r == 6'd1)
          busy <= 1'b0;
      end
    end
  end

  // results are taken from the last step itself so that the owner can
  // store them at the sixteenth clock instead of one clock later
  assign done      = busy && (cnt_r == 6'd1);
  assign quotient  = quoStep;
  assign remainder = remStep;
endmodule

// file: testbench/mdu_top_asserts.sv
// checker for the mul/div unit register port and interrupt
`timescale 1ns/10ps
module mdu_top_asserts (
  input wire logic        clock,   // system clock
  input wire logic        nrst,    // sync reset, low
  input wire logic        psel,    // apb select
  input wire logic        penable, // apb access phase
  input wire logic        pwrite,  // apb write
  input wire logic [7:0]  paddr,   // apb address
  input wire logic [31:0] pwdata,  // apb write data
  input wire logic [3:0]  pstrb,   // apb strobes
  input wire logic [31:0] prdata,  // apb read data
  input wire logic        pready,  // apb ready
  input wire logic        pslverr, // apb error
  input wire logic        irq      // level interrupt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // transfer commit and divide start as seen on the bus
  wire logic done = psel && penable && pready;
  wire logic goWr = done && pwrite && paddr == mdu_pkg::OFS_CONTROL
                    && pstrb[0] && pwdata[mdu_pkg::CTL_OP_SELECT_BIT]
                    && pwdata[mdu_pkg::CTL_DIVIDE_GO_BIT];
  logic [4:0] divCnt_r;
  // cycles left in a division; a start while busy is ignored
  always_ff @(posedge clock)
  begin
    if (!nrst)
      divCnt_r <= 5'h00;
    else if (goWr && divCnt_r == 5'h00)
      divCnt_r <= 5'(mdu_pkg::DIV_CLOCKS);
    else if (divCnt_r != 5'h00)
      divCnt_r <= divCnt_r - 5'h01;
  end

  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_HALF_WORD: assert property (pready && !pwrite && paddr < 8'h18
    |-> prdata[31:16] == 16'h0) else $error("upper half not zero");
  AST_DIV_BUSY: assert property (done && !pwrite
    && paddr == mdu_pkg::OFS_CONTROL && divCnt_r inside {[2:15]}
    |-> prdata[7:0] == 8'h81) else $error("control not busy");
  AST_DIV_ENDS: assert property (done && !pwrite
    && paddr == mdu_pkg::OFS_CONTROL && divCnt_r == 5'h00
    && $past(divCnt_r) == 5'h00 |-> !prdata[0])
    else $error("go bit not cleared");
  AST_MASK_OFF: assert property (done && pwrite && pstrb[0]
    && paddr == mdu_pkg::OFS_MASK && pwdata[1:0] == 2'b00 |=> ##1 !irq)
    else $error("masked interrupt still high");
  // main scenarios reached
  cover property (goWr);
  cover property ($rose(irq));
  cover property (done && pslverr);
endmodule

bind mdu_top mdu_top_asserts u_chk (.clock, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);

// file: testbench/tb_mdu_top.sv
// self-checking bench for the mul/div unit
`timescale 1ns/10ps
module tb_mdu_top;
  logic        clock;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors;
  int          checks_done;
  int          cycles;

  mdu_top dut_u (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    // no wait count assumed; only the bench timeout ends a hang
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    chk(32'(pready), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask

  // operand registers come out of reset cleared
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i));
      chk(rdat, 32'h0);
    end
  endtask

  // both operand orders; all-ones shows no truncation
  task automatic t_mul();
    wr(mdu_pkg::OFS_CONTROL, 32'h00);
    wr(mdu_pkg::OFS_A_LOW, 32'hffff);
    wr(mdu_pkg::OFS_A_HIGH, 32'hffff);
    rd(mdu_pkg::OFS_B_LOW);
    chk(rdat, 32'h0001);
    rd(mdu_pkg::OFS_B_HIGH);
    chk(rdat, 32'hfffe);
    wr(mdu_pkg::OFS_A_HIGH, 32'h0003);
    wr(mdu_pkg::OFS_A_LOW, 32'h0002);
    rd(mdu_pkg::OFS_B_LOW);
    chk(rdat, 32'h0006);
    rd(mdu_pkg::OFS_B_HIGH);
    chk(rdat, 32'h0000);
    rd(mdu_pkg::OFS_STATUS);
    chk(rdat, 32'h2);
  endtask

  // two divisions, interrupt unmasked then masked
  task automatic t_div();
    int n;
    logic [31:0] dv;
    logic [31:0] q;
    logic [31:0] r;
    for (int m = 1; m >= 0; m--)
    begin
      dv = m ? 32'h00010000 : 32'h00000010;
      q = m ? 32'h00001234 : 32'h01234567;
      r = m ? 32'h00005678 : 32'h00000008;
      wr(mdu_pkg::OFS_CONTROL, 32'h80);
      wr(mdu_pkg::OFS_MASK, 32'(m));
      wr(mdu_pkg::OFS_A_HIGH, 32'h1234);
      wr(mdu_pkg::OFS_A_LOW, 32'h5678);
      wr(mdu_pkg::OFS_B_HIGH, {16'h0, dv[31:16]});
      wr(mdu_pkg::OFS_B_LOW, {16'h0, dv[15:0]});
      wr(mdu_pkg::OFS_CONTROL, 32'h81);
      rd(mdu_pkg::OFS_CONTROL);
      chk(rdat, 32'h81);
      n = 0;
      while (irq !== 1'b1 && n < 30)
      begin
        @(posedge clock);
        n++;
      end
      chk(32'(irq), 32'(m));
      if (m == 1)
        chk(32'(n <= 16), 32'h1);
      rd(mdu_pkg::OFS_A_HIGH);
      chk(rdat, {16'h0, q[31:16]});
      rd(mdu_pkg::OFS_A_LOW);
      chk(rdat, {16'h0, q[15:0]});
      rd(mdu_pkg::OFS_REM_HIGH);
      chk(rdat, {16'h0, r[31:16]});
      rd(mdu_pkg::OFS_REM_LOW);
      chk(rdat, {16'h0, r[15:0]});
      rd(mdu_pkg::OFS_CONTROL);
      chk(rdat, 32'h80);
      rd(mdu_pkg::OFS_STATUS);
      chk(rdat, 32'h1);
      rd(mdu_pkg::OFS_STATUS);
      chk(rdat, 32'h0);
      repeat (2) @(posedge clock);
      chk(32'(irq), 32'h0);
    end
  endtask

  // unmapped place, read-only remainder, partial and full writes
  task automatic t_bus();
    rd(8'h24);
    chk({rdat[30:0], rerr}, 32'h1);
    wr(mdu_pkg::OFS_REM_LOW, 32'h1);
    rd(mdu_pkg::OFS_REM_LOW);
    chk(rdat, 32'h0008);
    apb(1'b1, mdu_pkg::OFS_B_LOW, 32'h5555, 4'h1);
    rd(mdu_pkg::OFS_B_LOW);
    chk(rdat, 32'h0010);
    wr(mdu_pkg::OFS_B_LOW, 32'hdeadbeef);
    rd(mdu_pkg::OFS_B_LOW);
    chk(rdat, 32'hbeef);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // a hang costs a mismatch; the run needs well under this
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_mul();
    t_div();
    t_bus();
    report_and_stop();
  end
endmodule
